// File: hdl/rtpas_defines.svh
// Purpose: constants for the realm pa-space select and permission block
// Assumes: avalon byte addresses, 32-bit registers
// Notes:   ctrl and descriptor field positions, offsets and reset values live here; the stat layout is packed in rtpas_top
//
// Contract
// R1: realm el1&0 s2 table lookups use realm space
// R2: el1&0 s2 leaf world bit 1 gives ns
// R3: el1&0 s2 disabled maps ipa to realm
// R4: s1 walk leaving realm gives s2 permission fault
// R5: vtcr bits 30:29 zero, no walk overrides
// R6: realm el2 s1 lookups use realm space
// R7: realm el2 leaf world bit 1 gives ns
// R8: realm el2 translation off uses realm
// R9: el2&0 output space same as el2
// R10: el2/el2&0 non-realm fetch gives s1 fault
// R11: el1&0 non-realm fetch gives s2 fault
// R12: optional ns mapping marked unprivileged execute-never
// R13: table bit 63 reserved, no hierarchical override
// R14: realm s2 leaf bit 55 is world bit
// R15: realm el2/el2&0 leaf bit 5 world bit
// R16: el3 s1 leaf bit 11 is extension bit
// R17: invalidate scope follows realm or el3 world bits
// R18: access flag update ignores granule check
// R19: dirty update allowed despite granule fault
// R20: at to lower levels undefined, world 10
// R21: at reports three granule table faults
// R22: at skips check on final output address
// R23: some at faults raise exceptions, else status field
// R24: el3 ext/world bits select output space
`ifndef RTPAS_DEFINES_SVH
`define RTPAS_DEFINES_SVH

`define RTPAS_CTRL_OFS      4'h0
`define RTPAS_VTCR_OFS      4'h4
`define RTPAS_STAT_OFS      4'h8
`define RTPAS_INVAL_OFS     4'hc

`define RTPAS_CTRL_RST      32'h0000_0000
`define RTPAS_VTCR_RST      32'h0000_0000
`define RTPAS_VTCR_RES0     32'h6000_0000

`define RTPAS_C_REGIME_LO   0
`define RTPAS_C_REGIME_HI   2
`define RTPAS_C_XLAT_EN     3
`define RTPAS_C_NS_XN       4
`define RTPAS_C_GPF_ROUTE   5
`define RTPAS_C_WORLD_LO    6
`define RTPAS_C_WORLD_HI    7
`define RTPAS_C_SEL2        8

`define RTPAS_S2_WORLD_BIT  55
`define RTPAS_S1_WORLD_BIT  5
`define RTPAS_EL3_EXT_BIT   11
`define RTPAS_TBL_OVR_BIT   63

`define RTPAS_WORLD_NOREG   2'h2

`define RTPAS_FS_GTBL_ASZ   6'h30
`define RTPAS_FS_GTBL_WALK  6'h31
`define RTPAS_FS_GTBL_SEA   6'h32
`define RTPAS_FS_GCHK       6'h33

`endif

// File: hdl/rtpas_pkg.sv
// Purpose: types for the realm pa-space select and permission block
// Assumes: space encoding equals {extension, world} bit pair
// Notes:   none
package rtpas_pkg;

  typedef enum logic [1:0] {
    RTPAS_SP_SEC   = 2'h0,
    RTPAS_SP_NS    = 2'h1,
    RTPAS_SP_ROOT  = 2'h2,
    RTPAS_SP_REALM = 2'h3
  } rtpas_space_e;

  typedef enum logic [2:0] {
    RTPAS_RG_OTHER  = 3'h0,
    RTPAS_RG_R_EL10 = 3'h1,
    RTPAS_RG_R_EL2  = 3'h2,
    RTPAS_RG_R_EL20 = 3'h3,
    RTPAS_RG_EL3    = 3'h4
  } rtpas_regime_e;

  typedef enum logic [1:0] {
    RTPAS_K_DATA   = 2'h0,
    RTPAS_K_FETCH  = 2'h1,
    RTPAS_K_S1WALK = 2'h2,
    RTPAS_K_TWALK  = 2'h3
  } rtpas_kind_e;

  typedef enum logic [2:0] {
    RTPAS_F_NONE     = 3'h0,
    RTPAS_F_GTBL_ASZ  = 3'h1,
    RTPAS_F_GTBL_WALK = 3'h2,
    RTPAS_F_GTBL_SEA  = 3'h3,
    RTPAS_F_GCHK      = 3'h4
  } rtpas_atf_e;

  typedef enum logic [1:0] {
    RTPAS_BUS_IDLE = 2'b01,
    RTPAS_BUS_ACK  = 2'b10
  } rtpas_bus_e;

endpackage

// File: hdl/rtpas_dec_if.sv
// Purpose: carries descriptor decode request and result
// Assumes: purely combinational decode
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface rtpas_dec_if;
  import rtpas_pkg::*;
  rtpas_regime_e regime;
  logic          xlat_en;
  logic          sel2;
  logic [63:0]   desc;
  logic          table_desc;
  rtpas_space_e  space;
  rtpas_space_e  walk_space;

  modport core (output regime, xlat_en, sel2, desc, table_desc,
                input  space, walk_space);
  modport dec  (input  regime, xlat_en, sel2, desc, table_desc,
                output space, walk_space);
endinterface
`default_nettype wire

// File: hdl/rtpas_space_dec.sv
// Purpose: output and walk physical space from regime and descriptor
// Assumes: desc holds the leaf of the stage that sets the output space
// Notes:   combinational
`timescale 1ns/1ps
`include "rtpas_defines.svh"
`default_nettype none
module rtpas_space_dec
  import rtpas_pkg::*;
(
  rtpas_dec_if.dec d  // decode request and result
);

  ////////////////////////////////////////////////////////////////////////
  // walk space; table bit 63 never steers it
  always_comb begin
    case (d.regime)
      RTPAS_RG_R_EL10: d.walk_space = RTPAS_SP_REALM; // R1 R13
      RTPAS_RG_R_EL2:  d.walk_space = RTPAS_SP_REALM; // R6 R13
      RTPAS_RG_R_EL20: d.walk_space = RTPAS_SP_REALM; // R6 R13
      RTPAS_RG_EL3:    d.walk_space = RTPAS_SP_ROOT;  // R13
      default:         d.walk_space = RTPAS_SP_NS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // leaf output space
  always_comb begin
    d.space = RTPAS_SP_NS;
    if (d.table_desc) begin
      d.space = d.walk_space;
    end else begin
      case (d.regime)
        RTPAS_RG_R_EL10: begin
          if (!d.xlat_en) d.space = RTPAS_SP_REALM; // R3
          else if (d.desc[`RTPAS_S2_WORLD_BIT])
            d.space = RTPAS_SP_NS; // R2 R14
          else d.space = RTPAS_SP_REALM; // R2
        end
        RTPAS_RG_R_EL2, RTPAS_RG_R_EL20: begin
          if (!d.xlat_en) d.space = RTPAS_SP_REALM; // R8
          else if (d.desc[`RTPAS_S1_WORLD_BIT])
            d.space = RTPAS_SP_NS; // R7 R9 R15
          else d.space = RTPAS_SP_REALM; // R7 R9
        end
        RTPAS_RG_EL3: begin
          if (!d.xlat_en) begin
            d.space = RTPAS_SP_ROOT;
          end else begin
            case ({d.desc[`RTPAS_EL3_EXT_BIT], d.desc[`RTPAS_S1_WORLD_BIT]})
              2'h0:    d.space = d.sel2 ? RTPAS_SP_SEC : RTPAS_SP_NS; // R24
              2'h1:    d.space = RTPAS_SP_NS;    // R24 R16
              2'h2:    d.space = RTPAS_SP_ROOT;  // R24 R16
              default: d.space = RTPAS_SP_REALM; // R24 R16
            endcase
          end
        end
        default: d.space = RTPAS_SP_NS;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: hdl/rtpas_top.sv
// Purpose: realm pa-space select, permission faults, inval scope, at faults
// Assumes: core requests are synchronous, one result a cycle later
// Notes:   avalon-mm slave with one wait state on every access
`timescale 1ns/1ps
`include "rtpas_defines.svh"
`default_nettype none
module rtpas_top
  import rtpas_pkg::*;
(
  input  wire logic          clk_i,            // core clock
  input  wire logic          rst_n_i,          // sync reset, low
  input  wire logic [3:0]    avs_address_i,    // byte address
  input  wire logic          avs_read_i,       // read request
  input  wire logic          avs_write_i,      // write request
  input  wire logic [31:0]   avs_writedata_i,  // write data
  input  wire logic [3:0]    avs_byteenable_i, // byte lanes
  output logic [31:0]        avs_readdata_o,   // read data
  output logic               avs_waitrequest_o,// stall
  input  wire logic          lk_valid_i,       // lookup request
  input  wire rtpas_kind_e   lk_kind_i,        // access kind
  input  wire logic [63:0]   lk_desc_i,        // descriptor
  input  wire logic          lk_table_i,       // descriptor is a table
  input  wire logic          lk_af_en_i,       // hw access flag enabled
  input  wire logic          lk_dirty_i,       // dirty update wanted
  input  wire logic          lk_final_i,       // final enabled stage
  output logic               lk_done_o,        // result pulse
  output rtpas_space_e       lk_space_o,       // physical space
  output logic               lk_s1_perm_o,     // stage 1 perm fault
  output logic               lk_s2_perm_o,     // stage 2 perm fault
  output logic               lk_unpriv_xn_o,   // unprivileged xn choice
  output logic               lk_af_wr_o,       // write access flag
  output logic               lk_dirty_wr_o,    // write dirty state
  input  wire logic          inval_valid_i,    // invalidate request
  input  wire logic          inval_el3_lower_i, // el3 aimed lower
  input  wire rtpas_space_e  cur_state_i,      // current security state
  output logic               inval_done_o,     // scope pulse
  output rtpas_space_e       inval_state_o,    // state to invalidate
  input  wire logic          at_valid_i,       // at instruction
  input  wire logic          at_el3_i,         // executed at el3
  input  wire logic          at_lower_i,       // targets e0/e1/e2
  input  wire logic          at_from_el1_i,    // executed at el1
  input  wire rtpas_atf_e    at_fault_i,       // fault seen by walk
  input  wire logic          at_on_s1_i,       // on s1 descriptor fetch
  input  wire logic          at_on_s2_i,       // on s2 descriptor fetch
  input  wire logic          at_final_oa_i,    // on final output addr
  input  wire logic          at_gchk_exc_i,    // granule check exception
  output logic               at_done_o,        // result pulse
  output logic               at_undef_o,       // undefined
  output logic               at_exc_o,         // taken as exception
  output logic               at_fstat_vld_o,   // fault in result reg
  output logic [5:0]         at_fstat_o        // fault status code
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] rtpas_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic rtpas_bad_fetch(input rtpas_kind_e  k,
                                           input rtpas_space_e s,
                                           input rtpas_space_e want);
    return (k == RTPAS_K_FETCH) && (s != want);
  endfunction

  function automatic logic [5:0] rtpas_fstat(input rtpas_atf_e f);
    case (f)
      RTPAS_F_GTBL_ASZ:  return `RTPAS_FS_GTBL_ASZ;
      RTPAS_F_GTBL_WALK: return `RTPAS_FS_GTBL_WALK;
      RTPAS_F_GTBL_SEA:  return `RTPAS_FS_GTBL_SEA;
      RTPAS_F_GCHK:      return `RTPAS_FS_GCHK;
      default:          return 6'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register bus
  rtpas_bus_e  bus_r;
  logic [31:0] ctrl_r;
  logic [31:0] vtcr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] stat_w;
  logic [31:0] inval_w;
  logic        acc_w;
  logic        wr_ack_w;

  assign acc_w             = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = acc_w && (bus_r == RTPAS_BUS_IDLE);
  assign wr_ack_w          = avs_write_i && (bus_r == RTPAS_BUS_ACK);
  assign avs_readdata_o    = rdata_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_r <= RTPAS_BUS_IDLE;
    end else begin
      case (bus_r)
        RTPAS_BUS_IDLE: if (acc_w) bus_r <= RTPAS_BUS_ACK;
        RTPAS_BUS_ACK:  bus_r <= RTPAS_BUS_IDLE;
        default:        bus_r <= RTPAS_BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (avs_address_i == `RTPAS_CTRL_OFS) begin
      rdata_nxt = ctrl_r;
    end else if (avs_address_i == `RTPAS_VTCR_OFS) begin
      rdata_nxt = vtcr_r;
    end else if (avs_address_i == `RTPAS_STAT_OFS) begin
      rdata_nxt = stat_w;
    end else if (avs_address_i == `RTPAS_INVAL_OFS) begin
      rdata_nxt = inval_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i && bus_r == RTPAS_BUS_IDLE) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `RTPAS_CTRL_RST;
      vtcr_r <= `RTPAS_VTCR_RST;
    end else if (wr_ack_w) begin
      if (avs_address_i == `RTPAS_CTRL_OFS) begin
        ctrl_r <= rtpas_merge(ctrl_r, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `RTPAS_VTCR_OFS) begin
        vtcr_r <= rtpas_merge(vtcr_r, avs_writedata_i, avs_byteenable_i)
                  & ~`RTPAS_VTCR_RES0; // R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control fields
  rtpas_regime_e regime_w;
  logic          xlat_en_w;
  logic          ns_as_xn_w;
  logic          gpf_route_w;
  logic [1:0]    world_w;

  assign regime_w    = rtpas_regime_e'(
                         ctrl_r[`RTPAS_C_REGIME_HI:`RTPAS_C_REGIME_LO]);
  assign xlat_en_w   = ctrl_r[`RTPAS_C_XLAT_EN];
  assign ns_as_xn_w  = ctrl_r[`RTPAS_C_NS_XN];
  assign gpf_route_w = ctrl_r[`RTPAS_C_GPF_ROUTE];
  assign world_w     = ctrl_r[`RTPAS_C_WORLD_HI:`RTPAS_C_WORLD_LO];

  ////////////////////////////////////////////////////////////////////////
  // lookup
  rtpas_dec_if dec_if ();

  assign dec_if.regime     = regime_w;
  assign dec_if.xlat_en    = xlat_en_w;
  assign dec_if.sel2       = ctrl_r[`RTPAS_C_SEL2];
  assign dec_if.desc       = lk_desc_i;
  assign dec_if.table_desc = lk_table_i || (lk_kind_i == RTPAS_K_TWALK);

  rtpas_space_dec u_dec (
    .d (dec_if.dec)
  );

  rtpas_space_e sp_w;
  logic         s1_perm_w;
  logic         s2_perm_w;
  assign sp_w = dec_if.space;

  always_comb begin
    s1_perm_w = 1'b0;
    s2_perm_w = 1'b0;
    case (regime_w)
      RTPAS_RG_R_EL10: begin
        s2_perm_w = rtpas_bad_fetch(lk_kind_i, sp_w, RTPAS_SP_REALM) // R11
                 || (lk_kind_i == RTPAS_K_S1WALK
                     && sp_w != RTPAS_SP_REALM);                     // R4
      end
      RTPAS_RG_R_EL2, RTPAS_RG_R_EL20: begin
        s1_perm_w = rtpas_bad_fetch(lk_kind_i, sp_w, RTPAS_SP_REALM); // R10
      end
      RTPAS_RG_EL3: begin
        s1_perm_w = rtpas_bad_fetch(lk_kind_i, sp_w, RTPAS_SP_ROOT);
      end
      default: begin
        s1_perm_w = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lk_done_o     <= 1'b0;
      lk_space_o    <= RTPAS_SP_SEC;
      lk_s1_perm_o  <= 1'b0;
      lk_s2_perm_o  <= 1'b0;
      lk_unpriv_xn_o <= 1'b0;
      lk_af_wr_o    <= 1'b0;
      lk_dirty_wr_o <= 1'b0;
    end else begin
      lk_done_o     <= lk_valid_i;
      lk_af_wr_o    <= lk_valid_i && lk_af_en_i; // R18
      lk_dirty_wr_o <= lk_valid_i && lk_dirty_i && lk_final_i; // R19
      if (lk_valid_i) begin
        lk_space_o   <= sp_w;
        lk_s1_perm_o <= s1_perm_w;
        lk_s2_perm_o <= s2_perm_w;
        lk_unpriv_xn_o <= ns_as_xn_w && regime_w == RTPAS_RG_R_EL20
                        && sp_w == RTPAS_SP_NS; // R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tlb invalidation scope
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      inval_done_o  <= 1'b0;
      inval_state_o <= RTPAS_SP_SEC;
    end else begin
      inval_done_o <= inval_valid_i;
      if (inval_valid_i) begin
        inval_state_o <= inval_el3_lower_i ? rtpas_space_e'(world_w)
                                           : cur_state_i; // R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address translation instruction faults
  rtpas_atf_e eff_w;
  logic       undef_w;
  logic       exc_w;

  assign undef_w = at_el3_i && at_lower_i
                   && world_w == `RTPAS_WORLD_NOREG; // R20
  assign eff_w   = (at_final_oa_i && at_fault_i == RTPAS_F_GCHK)
                   ? RTPAS_F_NONE : at_fault_i; // R22
  assign exc_w   = !undef_w && eff_w != RTPAS_F_NONE
                   && (at_gchk_exc_i
                       || (at_from_el1_i && at_on_s2_i)
                       || (at_from_el1_i && at_on_s1_i
                           && gpf_route_w)); // R23

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      at_done_o      <= 1'b0;
      at_undef_o     <= 1'b0;
      at_exc_o       <= 1'b0;
      at_fstat_vld_o <= 1'b0;
      at_fstat_o     <= 6'h00;
    end else begin
      at_done_o <= at_valid_i;
      if (at_valid_i) begin
        at_undef_o     <= undef_w;
        at_exc_o       <= exc_w;
        at_fstat_vld_o <= !undef_w && !exc_w && eff_w != RTPAS_F_NONE;
        at_fstat_o     <= (undef_w || exc_w) ? 6'h00
                          : rtpas_fstat(eff_w); // R21 R23
      end
    end
  end

  assign stat_w = {19'h0, at_fstat_vld_o, at_exc_o, at_undef_o,
                   lk_dirty_wr_o, lk_af_wr_o, lk_unpriv_xn_o, lk_s2_perm_o,
                   lk_s1_perm_o, 3'h0, lk_space_o};
  assign inval_w = {30'h0, inval_state_o};

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking core_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_vtcr_res0_zero: assert property ( // R5
    (vtcr_r & `RTPAS_VTCR_RES0) == 32'h0)
    else $error("vtcr reserved bits set");

  a_el10_fetch_fault: assert property ( // R11
    lk_valid_i && regime_w == RTPAS_RG_R_EL10 && lk_kind_i == RTPAS_K_FETCH
    |=> lk_s2_perm_o == (lk_space_o != RTPAS_SP_REALM) && !lk_s1_perm_o)
    else $error("el1 fetch fault wrong");

  a_el10_walk_fault: assert property ( // R4
    lk_valid_i && regime_w == RTPAS_RG_R_EL10 && lk_kind_i == RTPAS_K_S1WALK
    && xlat_en_w && lk_desc_i[`RTPAS_S2_WORLD_BIT] && !lk_table_i
    |=> lk_done_o && lk_s2_perm_o && lk_space_o == RTPAS_SP_NS)
    else $error("s1 walk to ns without s2 fault");

  a_el10_s2_off: assert property ( // R3
    lk_valid_i && regime_w == RTPAS_RG_R_EL10 && !xlat_en_w
    |=> lk_space_o == RTPAS_SP_REALM && !lk_s2_perm_o)
    else $error("s2 off not realm");

  a_el2_fetch_fault: assert property ( // R10
    lk_valid_i && (regime_w == RTPAS_RG_R_EL2 || regime_w == RTPAS_RG_R_EL20)
    && lk_kind_i == RTPAS_K_FETCH
    |=> lk_s1_perm_o == (lk_space_o != RTPAS_SP_REALM) && !lk_s2_perm_o)
    else $error("el2 fetch fault wrong");

  a_el2_world_sel: assert property ( // R7
    lk_valid_i && regime_w == RTPAS_RG_R_EL2 && xlat_en_w && !lk_table_i
    && lk_kind_i != RTPAS_K_TWALK
    |=> lk_space_o == ($past(lk_desc_i[`RTPAS_S1_WORLD_BIT])
                       ? RTPAS_SP_NS : RTPAS_SP_REALM))
    else $error("el2 world bit ignored");

  a_table_realm: assert property ( // R13
    lk_valid_i && lk_table_i && regime_w == RTPAS_RG_R_EL20
    && lk_desc_i[`RTPAS_TBL_OVR_BIT] |=> lk_space_o == RTPAS_SP_REALM)
    else $error("table override honoured");

  a_el3_ext_sel: assert property ( // R24
    lk_valid_i && regime_w == RTPAS_RG_EL3 && xlat_en_w && !lk_table_i
    && lk_kind_i == RTPAS_K_DATA |=>
    lk_space_o[1] == $past(lk_desc_i[`RTPAS_EL3_EXT_BIT]))
    else $error("el3 extension bit ignored");

  a_at_undef_el3: assert property ( // R20
    at_valid_i && at_el3_i && at_lower_i && world_w == `RTPAS_WORLD_NOREG
    |=> at_undef_o && !at_exc_o && !at_fstat_vld_o)
    else $error("at not undefined");

  a_at_final_skip: assert property ( // R22
    at_valid_i && at_final_oa_i && at_fault_i == RTPAS_F_GCHK
    |=> !at_exc_o && !at_fstat_vld_o)
    else $error("final oa checked");

  a_dirty_gpc: assert property ( // R19
    lk_valid_i && lk_dirty_i && lk_final_i |=> lk_dirty_wr_o && lk_done_o)
    else $error("dirty update lost");

  a_bus_one_wait: assert property (
    acc_w && bus_r == RTPAS_BUS_IDLE |=> !avs_waitrequest_o)
    else $error("bus wait not one cycle");

endmodule
`default_nettype wire

// File: sim/rtpas_core_mdl.sv
// Purpose: core side model issuing one lookup per go pulse
// Assumes: fields launch one edge after go, valid lasts one cycle
// Notes:   fields turn to junk outside a request, as a real core may
`timescale 1ns/1ps
`default_nettype none
module rtpas_core_mdl
  import rtpas_pkg::*;
(
  input  wire logic        clk_i,   // core clock
  input  wire logic        rst_n_i, // sync reset, low
  input  wire logic        go_i,    // launch lookup
  input  wire logic [69:0] req_i,   // {kind,af,dirty,final,table,desc}
  output logic             vld_o,   // lookup valid
  output logic [69:0]      req_o    // lookup fields
);
  always_ff @(posedge clk_i) begin
    vld_o <= go_i & rst_n_i;
    req_o <= go_i ? req_i : ~req_o;
  end
endmodule
`default_nettype wire

// File: sim/rtpas_top_tb.sv
// Purpose: random and corner checks of space select and fault logic
// Assumes: one wait state per bus access, results one cycle on
// Notes:   lookup, invalidate and at requests are launched together
`timescale 1ns/1ps
`include "rtpas_defines.svh"
`default_nettype none
module rtpas_top_tb;
  import rtpas_pkg::*;
  logic         clk, rst_n, rd, wr, go, mv, tv, tl, av, ae, al, a1;
  logic         as1, as2, afo, agx, ld, lp1, lp2, lux, law, ldw, td;
  logic         adn, au, ax, afv, wq, t, un, f, ex;
  logic [1:0]   k, sp;
  logic [3:0]   a, be;
  logic [5:0]   afs;
  logic [31:0]  wd, rdat, q, c;
  logic [69:0]  req, mreq;
  rtpas_space_e cs, lsp, ts;
  rtpas_atf_e   af, ef;
  int           miscompares, check_count;
  rtpas_core_mdl i_rtpas_core_mdl (.clk_i(clk), .rst_n_i(rst_n),
    .go_i(go), .req_i(req), .vld_o(mv), .req_o(mreq));
  rtpas_top i_rtpas_top (
    .clk_i(clk), .rst_n_i(rst_n), .avs_address_i(a), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .lk_valid_i(mv),
    .lk_kind_i(rtpas_kind_e'(mreq[69:68])), .lk_af_en_i(mreq[67]),
    .lk_dirty_i(mreq[66]), .lk_final_i(mreq[65]), .lk_table_i(mreq[64]),
    .lk_desc_i(mreq[63:0]), .lk_done_o(ld), .lk_space_o(lsp),
    .lk_s1_perm_o(lp1), .lk_s2_perm_o(lp2), .lk_unpriv_xn_o(lux),
    .lk_af_wr_o(law), .lk_dirty_wr_o(ldw), .inval_valid_i(tv),
    .inval_el3_lower_i(tl), .cur_state_i(cs), .inval_done_o(td),
    .inval_state_o(ts), .at_valid_i(av), .at_el3_i(ae), .at_lower_i(al),
    .at_from_el1_i(a1), .at_fault_i(af), .at_on_s1_i(as1),
    .at_on_s2_i(as2), .at_final_oa_i(afo), .at_gchk_exc_i(agx),
    .at_done_o(adn), .at_undef_o(au), .at_exc_o(ax),
    .at_fstat_vld_o(afv), .at_fstat_o(afs));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask
  // hold request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] ad_,
                     input logic [31:0] d, input logic [3:0] b);
    a <= ad_;
    wr <= w;
    rd <= !w;
    wd <= d;
    be <= b;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [1:0] esp(logic [31:0] c_, logic [63:0] d,
                                     logic t_);
    if (c_[2:0] == 3'h0) return 2'h1;
    if (t_) return c_[2:0] == 3'h4 ? 2'h2 : 2'h3;
    if (c_[2:0] == 3'h4) begin
      if (!c_[3]) return 2'h2;
      if ({d[11], d[5]} == 2'h0) return c_[8] ? 2'h0 : 2'h1;
      return {d[11], d[5]};
    end
    if (!c_[3]) return 2'h3;
    if (c_[2:0] == 3'h1) return d[55] ? 2'h1 : 2'h3;
    return d[5] ? 2'h1 : 2'h3;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    {rst_n, rd, wr, go, tv, tl, av, ae, al, a1, as1, as2, afo, agx} = '0;
    {a, be, wd, req} = '0;
    cs = RTPAS_SP_SEC;
    af = RTPAS_F_NONE;
    void'($urandom(77));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `RTPAS_CTRL_OFS, 32'h0, 4'hf);
    chk(q, `RTPAS_CTRL_RST);
    bus(1'b0, `RTPAS_VTCR_OFS, 32'h0, 4'hf);
    chk(q, `RTPAS_VTCR_RST);
    bus(1'b1, `RTPAS_VTCR_OFS, 32'hffff_ffff, 4'hf);
    bus(1'b0, `RTPAS_VTCR_OFS, 32'h0, 4'hf);
    chk(q, 32'h9fff_ffff);
    bus(1'b1, `RTPAS_VTCR_OFS, 32'h0, 4'h1);
    bus(1'b0, `RTPAS_VTCR_OFS, 32'h0, 4'hf);
    chk(q, 32'h9fff_ff00);
    bus(1'b0, 4'h1, 32'h0, 4'hf);
    chk(q, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 80; i++) begin
      c = ($urandom & 32'h1f8) | 32'($urandom_range(4));
      k = 2'($urandom_range(3));
      t = k == 2'h3 || (k == 2'h0 && $urandom_range(1) == 1);
      bus(1'b1, `RTPAS_CTRL_OFS, c, 4'hf);
      req <= {k, 3'($urandom_range(7)), t, $urandom, $urandom};
      {tl, ae, al, a1, as1, as2, afo, agx} <= 8'($urandom_range(255));
      cs <= rtpas_space_e'($urandom_range(3));
      af <= rtpas_atf_e'($urandom_range(4));
      go <= 1'b1;
      tv <= 1'b1;
      av <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      tv <= 1'b0;
      av <= 1'b0;
      #1;
      chk(td, 1'b1);
      chk(ts, tl ? c[7:6] : cs);
      un = ae & al & (c[7:6] == 2'b10);
      ef = (af == RTPAS_F_GCHK && afo) ? RTPAS_F_NONE : af;
      f = !un && ef != RTPAS_F_NONE;
      ex = f & (agx | a1 & as2 | a1 & as1 & c[5]);
      chk(adn, 1'b1);
      chk(au, un);
      chk(ax, ex);
      chk(afv, f & !ex);
      chk(afs, f & !ex ? `RTPAS_FS_GTBL_ASZ - 6'h1 + ef : 6'h0);
      @(posedge clk);
      #1;
      sp = esp(c, req[63:0], t);
      chk(ld, 1'b1);
      chk(lsp, sp);
      chk(lp1, k == 2'h1 && ((c[2:0] inside {3'h2, 3'h3} && sp != 2'h3)
        || (c[2:0] == 3'h4 && sp != 2'h2)));
      chk(lp2, c[2:0] == 3'h1 && k inside {2'h1, 2'h2} && sp != 2'h3);
      chk(lux, c[2:0] == 3'h3 && sp == 2'h1 && c[4] && !t);
      chk(law, req[67]);
      chk(ldw, req[66] & req[65]);
      @(posedge clk);
      #1;
      chk({ld, law, ldw}, 3'h0);
      @(posedge clk);
    end
    $display("test random done");
    stop_test();
  end
endmodule
`default_nettype wire
